// *** gpio_pkg.sv ***
// Shared constants for the general-purpose pin block
package gpio_pkg;
  // ****************************************
  // Port geometry
  // ****************************************
  localparam int unsigned NUM_PORTS    = 4;
  localparam int unsigned PORT_W       = 8;
  localparam int unsigned MAX_PINS     = 25;
  localparam int unsigned PORT_A       = 0;
  localparam int unsigned PORT_B       = 1;
  localparam int unsigned PORT_C       = 2;
  localparam int unsigned PORT_D       = 3;
  localparam int unsigned PB_HI_LO     = 6;
  localparam int unsigned LED_LVL_W    = 2;

  // ****************************************
  // Package variants
  // ****************************************
  localparam logic [1:0] PKG_8PIN  = 2'h0;
  localparam logic [1:0] PKG_20PIN = 2'h1;
  localparam logic [1:0] PKG_28PIN = 2'h2;

  // Per-port pin presence masks
  localparam logic [7:0] MASK_NONE    = 8'h00;
  localparam logic [7:0] MASK_ALL     = 8'hff;
  localparam logic [7:0] MASK_LOW6    = 8'h3f;
  localparam logic [7:0] MASK_LOW4    = 8'h0f;
  localparam logic [7:0] MASK_BIT0    = 8'h01;
  localparam logic [7:0] MASK_PB_HIGH = 8'hc0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_DIR_IN   = 8'hff;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic       RST_SRST_PIN = 1'b1;

  // ****************************************
  // Shared reset pin states
  // ****************************************
  typedef enum logic [2:0] {
    SRST_ASSERT = 3'b001,
    SRST_RESET  = 3'b010,
    SRST_GPIO   = 3'b100
  } srst_state_t;

  // Presence of pins per port for a package and converter option
  function automatic logic [7:0] port_mask(input logic [1:0] pkg, input logic has_adc, input int unsigned port);
    logic [7:0] m;
    m = MASK_NONE;
    unique case (pkg)
      PKG_8PIN: begin
        if (port == PORT_A) m = MASK_LOW6;
      end
      PKG_20PIN: begin
        if (port == PORT_A) m = MASK_ALL;
        else if (port == PORT_D) m = MASK_BIT0;
        else m = MASK_LOW4;
      end
      default: begin
        if (port == PORT_A || port == PORT_C) m = MASK_ALL;
        else if (port == PORT_D) m = MASK_BIT0;
        else m = has_adc ? (MASK_ALL & ~MASK_PB_HIGH) : MASK_ALL;
      end
    endcase
    return m;
  endfunction
endpackage

// *** gpio_pin_slice.sv ***
// One port of eight pins: output select, enables and input synchroniser
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_slice
  import gpio_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // Pin presence and configuration
  input  wire logic [PORT_W-1:0] present,
  input  wire logic [PORT_W-1:0] dir_in,
  input  wire logic [PORT_W-1:0] open_drain,
  input  wire logic [PORT_W-1:0] alt_en,
  input  wire logic [PORT_W-1:0] out_data,
  input  wire logic [PORT_W-1:0] alt_out,
  input  wire logic [PORT_W-1:0] alt_oe,
  input  wire logic [PORT_W-1:0] led_en,
  // Pad side
  input  wire logic [PORT_W-1:0] pad_in,
  output logic      [PORT_W-1:0] pad_out,
  output logic      [PORT_W-1:0] pad_oe_n,
  // Synchronised pin levels
  output logic      [PORT_W-1:0] pin_level
);
  logic [PORT_W-1:0] meta_q;
  logic [PORT_W-1:0] meta_d;
  logic [PORT_W-1:0] level_q;
  logic [PORT_W-1:0] level_d;
  logic [PORT_W-1:0] val;
  logic [PORT_W-1:0] drive;

  // ****************************************
  // Output path
  // ****************************************
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      val[i]   = alt_en[i] ? alt_out[i] : out_data[i];
      // Peripheral owns direction in alternate mode
      drive[i] = alt_en[i] ? alt_oe[i] : ~dir_in[i];
      // Open drain only drives lows; LED sink is always a low drive
      if (led_en[i]) begin
        val[i]   = 1'b0;
        drive[i] = 1'b1;
      end else if (open_drain[i] && val[i]) begin
        drive[i] = 1'b0;
      end
      if (!present[i]) begin
        drive[i] = 1'b0;
      end
      pad_out[i]  = val[i] & drive[i];
      pad_oe_n[i] = ~drive[i];
    end
  end

  // ****************************************
  // Input synchroniser
  // ****************************************
  // Raw pad goes straight into the first flop; nothing else may read it
  always_comb begin
    meta_d  = pad_in;
    level_d = meta_q;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_q  <= RST_ZERO;
      level_q <= RST_ZERO;
    end else begin
      meta_q  <= meta_d;
      level_q <= level_d;
    end
  end

  // Absent pins read low, masked only after the second flop
  assign pin_level = level_q & present;
endmodule
`default_nettype wire

// *** gpio_port_pin_control.sv ***
// General-purpose pin block: four ports, per-pin control, shared reset pin
`timescale 1ns/1ps
`default_nettype none
module gpio_port_pin_control
  import gpio_pkg::*;
(
  // Clock and reset
  input  wire logic                                clk_sys,
  input  wire logic                                arst_n,
  // Variant straps
  input  wire logic [1:0]                          pkg_sel,
  input  wire logic                                has_adc,
  // Chip reset request from reset controller (held while in reset)
  input  wire logic                                chip_in_reset,
  // Software write strobe and data per port
  input  wire logic [NUM_PORTS-1:0]                cfg_we,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    dir_in_wr,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    open_drain_wr,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    drive_high_wr,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    pullup_en_wr,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    wake_en_wr,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    alt_en_wr,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    out_data_wr,
  // LED drive on the third port
  input  wire logic                                led_we,
  input  wire logic [PORT_W-1:0]                   led_en_wr,
  input  wire logic [PORT_W-1:0][LED_LVL_W-1:0]    led_lvl_wr,
  // Shared reset pin mode: 1 returns to general-purpose use
  input  wire logic                                srst_gpio_wr,
  input  wire logic                                srst_we,
  // Peripheral alternate-function side
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    alt_out,
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    alt_oe,
  // Pads
  input  wire logic [NUM_PORTS-1:0][PORT_W-1:0]    pad_in,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]    pad_out,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]    pad_oe_n,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]    pad_drive_high,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]    pad_pullup_en,
  output logic      [PORT_W-1:0][LED_LVL_W-1:0]    led_level,
  // Readback and status
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]    pin_level,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]    port_present,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]    cfg_dir_in,
  output logic      [NUM_PORTS-1:0][PORT_W-1:0]    cfg_out_data,
  output logic                                     stop_wake,
  output logic                                     srst_is_reset,
  output logic                                     srst_reset_req
);
  // ****************************************
  // Per-pin configuration registers
  // ****************************************
  logic [NUM_PORTS-1:0][PORT_W-1:0] dir_q,  dir_d;
  logic [NUM_PORTS-1:0][PORT_W-1:0] od_q,   od_d;
  logic [NUM_PORTS-1:0][PORT_W-1:0] dh_q,   dh_d;
  logic [NUM_PORTS-1:0][PORT_W-1:0] pu_q,   pu_d;
  logic [NUM_PORTS-1:0][PORT_W-1:0] wk_q,   wk_d;
  logic [NUM_PORTS-1:0][PORT_W-1:0] af_q,   af_d;
  logic [NUM_PORTS-1:0][PORT_W-1:0] dout_q, dout_d;
  logic [PORT_W-1:0]                led_en_q, led_en_d;
  logic [PORT_W-1:0][LED_LVL_W-1:0] led_lvl_q, led_lvl_d;
  logic [NUM_PORTS-1:0][PORT_W-1:0] present;
  logic [NUM_PORTS-1:0][PORT_W-1:0] eff_dir;
  logic [NUM_PORTS-1:0][PORT_W-1:0] slice_out;
  logic [NUM_PORTS-1:0][PORT_W-1:0] slice_oe_n;
  logic [NUM_PORTS-1:0][PORT_W-1:0] lvl;
  logic [NUM_PORTS-1:0][PORT_W-1:0] lvl_prev_q, lvl_prev_d;
  logic [NUM_PORTS-1:0][PORT_W-1:0] zero_led;
  logic                             rst_pin_idx_a;
  srst_state_t                      srst_q, srst_d;

  // Shared reset pin sits on port D bit 0, or port A bit 2 on the smallest package
  assign rst_pin_idx_a = (pkg_sel == PKG_8PIN);

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      present[p] = port_mask(pkg_sel, has_adc, p);
    end
  end

  always_comb begin
    dir_d     = dir_q;
    od_d      = od_q;
    dh_d      = dh_q;
    pu_d      = pu_q;
    wk_d      = wk_q;
    af_d      = af_q;
    dout_d    = dout_q;
    led_en_d  = led_en_q;
    led_lvl_d = led_lvl_q;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (cfg_we[p]) begin
        // Absent pins keep reset settings so software cannot wake them
        dir_d[p]  = dir_in_wr[p] | ~present[p];
        od_d[p]   = open_drain_wr[p] & present[p];
        dh_d[p]   = drive_high_wr[p] & present[p];
        pu_d[p]   = pullup_en_wr[p] & present[p];
        wk_d[p]   = wake_en_wr[p] & present[p];
        af_d[p]   = alt_en_wr[p] & present[p];
        dout_d[p] = out_data_wr[p] & present[p];
      end
    end
    if (led_we) begin
      led_en_d  = led_en_wr & present[PORT_C];
      led_lvl_d = led_lvl_wr;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dir_q     <= {NUM_PORTS{RST_DIR_IN}};
      od_q      <= '0;
      dh_q      <= '0;
      pu_q      <= '0;
      wk_q      <= '0;
      af_q      <= '0;
      dout_q    <= '0;
      led_en_q  <= RST_ZERO;
      led_lvl_q <= '0;
    end else begin
      dir_q     <= dir_d;
      od_q      <= od_d;
      dh_q      <= dh_d;
      pu_q      <= pu_d;
      wk_q      <= wk_d;
      af_q      <= af_d;
      dout_q    <= dout_d;
      led_en_q  <= led_en_d;
      led_lvl_q <= led_lvl_d;
    end
  end

  // ****************************************
  // Shared reset pin mode
  // ****************************************
  always_comb begin
    srst_d = srst_q;
    unique case (srst_q)
      SRST_ASSERT: srst_d = chip_in_reset ? SRST_ASSERT : SRST_RESET;
      SRST_RESET: begin
        if (chip_in_reset) srst_d = SRST_ASSERT;
        else if (srst_we && srst_gpio_wr) srst_d = SRST_GPIO;
      end
      SRST_GPIO: begin
        if (chip_in_reset) srst_d = SRST_ASSERT;
        else if (srst_we && !srst_gpio_wr) srst_d = SRST_RESET;
      end
      default: srst_d = SRST_ASSERT;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      srst_q <= SRST_ASSERT;
    end else begin
      srst_q <= srst_d;
    end
  end

  // Larger packages force the shared pin to output when in general mode
  always_comb begin
    eff_dir = dir_q;
    if (!rst_pin_idx_a) begin
      eff_dir[PORT_D][0] = 1'b0;
    end
  end

  // ****************************************
  // Pin slices
  // ****************************************
  assign zero_led = '0;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    gpio_pin_slice u_slice (
      .clk_sys    (clk_sys),
      .arst_n     (arst_n),
      .present    (present[p]),
      .dir_in     (eff_dir[p]),
      .open_drain (od_q[p]),
      .alt_en     (af_q[p]),
      .out_data   (dout_q[p]),
      .alt_out    (alt_out[p]),
      .alt_oe     (alt_oe[p]),
      .led_en     ((p == PORT_C) ? led_en_q : zero_led[p]),
      .pad_in     (pad_in[p]),
      .pad_out    (slice_out[p]),
      .pad_oe_n   (slice_oe_n[p]),
      .pin_level  (lvl[p])
    );
  end

  // Override the shared pin while it acts as reset: open drain low in reset, else released
  always_comb begin
    pad_out  = slice_out;
    pad_oe_n = slice_oe_n;
    if (srst_q != SRST_GPIO) begin
      if (rst_pin_idx_a) begin
        pad_out[PORT_A][2]  = 1'b0;
        pad_oe_n[PORT_A][2] = (srst_q == SRST_ASSERT) ? 1'b0 : 1'b1;
      end else begin
        pad_out[PORT_D][0]  = 1'b0;
        pad_oe_n[PORT_D][0] = (srst_q == SRST_ASSERT) ? 1'b0 : 1'b1;
      end
    end
  end

  // ****************************************
  // Status, wake-up and pull-ups
  // ****************************************
  always_comb begin
    lvl_prev_d = lvl;
    stop_wake  = |((lvl ^ lvl_prev_q) & wk_q);
    pad_pullup_en = pu_q;
    // Reset function keeps its pull-up always on
    if (srst_q != SRST_GPIO) begin
      if (rst_pin_idx_a) pad_pullup_en[PORT_A][2] = 1'b1;
      else pad_pullup_en[PORT_D][0] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lvl_prev_q <= '0;
    end else begin
      lvl_prev_q <= lvl_prev_d;
    end
  end

  // Shared pin low while in reset mode requests a chip reset
  assign srst_reset_req = (srst_q == SRST_RESET) &&
                          (rst_pin_idx_a ? !lvl[PORT_A][2] : !lvl[PORT_D][0]);
  assign pad_drive_high = dh_q;
  assign led_level      = led_lvl_q;
  assign pin_level      = lvl;
  assign port_present   = present;
  assign cfg_dir_in     = dir_q;
  assign cfg_out_data   = dout_q;
  assign srst_is_reset  = (srst_q != SRST_GPIO);
endmodule
`default_nettype wire

// *** gpio_pin_props_properties.sv ***
// Port-level assertions for the pin block
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_props
  import gpio_pkg::*;
(
  // Clock, reset and straps
  input wire logic            clk_sys,
  input wire logic            arst_n,
  input wire logic [1:0]      pkg_sel,
  input wire logic            has_adc,
  // Requests
  input wire logic            chip_in_reset,
  input wire logic            srst_we,
  input wire logic [3:0]      cfg_we,
  input wire logic [3:0][7:0] dir_in_wr,
  input wire logic [3:0][7:0] alt_oe,
  // Pads and readback
  input wire logic [3:0][7:0] pad_in,
  input wire logic [3:0][7:0] pad_out,
  input wire logic [3:0][7:0] pad_oe_n,
  input wire logic [3:0][7:0] pin_level,
  input wire logic [3:0][7:0] port_present,
  input wire logic [3:0][7:0] cfg_dir_in,
  input wire logic [3:0][7:0] cfg_out_data,
  input wire logic            srst_is_reset
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  logic shr_oe_n;
  logic shr_out;
  // The shared pin moves with the package strap
  assign shr_oe_n = (pkg_sel == PKG_8PIN) ? pad_oe_n[0][2] : pad_oe_n[3][0];
  assign shr_out  = (pkg_sel == PKG_8PIN) ? pad_out[0][2] : pad_out[3][0];
  sequence held_in_reset;
    chip_in_reset [*2];
  endsequence
  absent_quiet_a: assert property (&(pad_oe_n | port_present))
    else $error("absent pin drives");
  absent_read_a: assert property ((pin_level & ~port_present) == '0)
    else $error("absent pin reads high");
  absent_cfg_a: assert property (&(cfg_dir_in | port_present) && (cfg_out_data & ~port_present) == '0)
    else $error("absent pin config kept");
  top_bits_a: assert property (pkg_sel == PKG_28PIN |-> port_present[1][7:6] == {2{!has_adc}})
    else $error("second port top bits wrong");
  for (genvar q = 1; q < 3; q++) begin : g_dir
    dir_write_a: assert property (cfg_we[q] |=>
      cfg_dir_in[q] == ($past(dir_in_wr[q]) | ~port_present[q]))
      else $error("direction write lost");
  end
  reset_fn_a: assert property (held_in_reset |-> srst_is_reset)
    else $error("shared pin left reset function");
  reset_stay_a: assert property (srst_is_reset && !srst_we |=> srst_is_reset)
    else $error("shared pin mode changed unasked");
  reset_low_a: assert property (held_in_reset |-> !shr_oe_n && !shr_out)
    else $error("shared pin not pulled low");
  out_only_a: assert property (!srst_is_reset && pkg_sel != PKG_8PIN && !cfg_out_data[3][0]
    && alt_oe[3][0] |-> !pad_oe_n[3][0])
    else $error("shared pin not driving");
  sync_delay_a: assert property ($past(arst_n) && $past(arst_n, 2)
    |-> pin_level == ($past(pad_in, 2) & port_present))
    else $error("pin level not two cycles late");
endmodule
bind gpio_port_pin_control gpio_pin_props u_props (.clk_sys(clk_sys), .arst_n(arst_n), .pkg_sel(pkg_sel),
  .has_adc(has_adc), .chip_in_reset(chip_in_reset), .srst_we(srst_we), .cfg_we(cfg_we), .dir_in_wr(dir_in_wr),
  .alt_oe(alt_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pin_level(pin_level),
  .port_present(port_present), .cfg_dir_in(cfg_dir_in), .cfg_out_data(cfg_out_data), .srst_is_reset(srst_is_reset));
`default_nettype wire

// *** gpio_board_model.sv ***
// Board-side model: the level each pad reads back
`timescale 1ns/1ps
`default_nettype none
module gpio_board_model (
  // Chip side of the pads
  input  wire logic [3:0][7:0] pad_out,
  input  wire logic [3:0][7:0] pad_oe_n,
  input  wire logic [3:0][7:0] pad_pullup_en,
  // Board drive on released pads, changed by the bench on every port configuration write
  input  wire logic [3:0][7:0] ext_level,
  output logic      [3:0][7:0] pad_in
);
  // A released pad never keeps the chip's value: pull-up wins, else the board
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & (pad_pullup_en | ext_level));
endmodule
`default_nettype wire

// *** gpio_port_pin_control_bench.sv ***
// Self-checking bench for the general-purpose pin block
`timescale 1ns/1ps
`default_nettype none
module gpio_port_pin_control_bench;
  import gpio_pkg::*;
  typedef logic [3:0][7:0] grid_t;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic [1:0]  pkg_sel = 2'h0;
  logic        has_adc = 1'b0;
  logic        chip_in_reset = 1'b1;
  logic [3:0]  cfg_we = 4'h0;
  logic        led_we = 1'b0;
  logic        srst_we = 1'b0;
  logic        srst_gpio_wr = 1'b0;
  logic [7:0]  led_en_wr = 8'h00;
  logic [15:0] led_lvl_wr = 16'h0000;
  logic [15:0] led_level;
  logic        stop_wake;
  logic        srst_is_reset;
  grid_t       dir_w = '1, od_w = '0, dh_w = '0, pu_w = '0, wk_w = '0, alt_w = '0, out_w = '0;
  grid_t       a_out = '0, a_oe = '0, ext = '0;
  grid_t       pad_in, pad_out, pad_oe_n, pad_drive_high, pad_pullup_en;
  grid_t       pin_level, port_present, cfg_dir_in, cfg_out_data;
  grid_t       m, shr, d_m, od_m, o_m, al_m, eoe, care, ld;
  int          fail_count = 0, tests_run = 0, v, i;
  always #2.5 clk_sys = ~clk_sys;
  gpio_board_model board (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en),
    .ext_level(ext), .pad_in(pad_in));
  gpio_port_pin_control DUT (.clk_sys(clk_sys), .arst_n(arst_n), .pkg_sel(pkg_sel), .has_adc(has_adc),
    .chip_in_reset(chip_in_reset), .cfg_we(cfg_we), .dir_in_wr(dir_w), .open_drain_wr(od_w),
    .drive_high_wr(dh_w), .pullup_en_wr(pu_w), .wake_en_wr(wk_w), .alt_en_wr(alt_w), .out_data_wr(out_w),
    .led_we(led_we), .led_en_wr(led_en_wr), .led_lvl_wr(led_lvl_wr), .srst_gpio_wr(srst_gpio_wr),
    .srst_we(srst_we), .alt_out(a_out), .alt_oe(a_oe), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_drive_high(pad_drive_high), .pad_pullup_en(pad_pullup_en),
    .led_level(led_level), .pin_level(pin_level), .port_present(port_present), .cfg_dir_in(cfg_dir_in),
    .cfg_out_data(cfg_out_data), .stop_wake(stop_wake), .srst_is_reset(srst_is_reset), .srst_reset_req());
  // ****
  // Checking helpers
  // ****
  task automatic cmp(input grid_t got, input grid_t exp, input grid_t cr);
    tests_run++;
    if ((got & cr) !== (exp & cr)) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got & cr, exp & cr);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Presence per variant, ports in D C B A order: 6, 17, 23 and 25 pins
  function automatic grid_t exp_mask(input int w);
    case (w)
      0: return 32'h0000_003f;
      1: return 32'h010f_0fff;
      2: return 32'h01ff_3fff;
      default: return 32'h01ff_ffff;
    endcase
  endfunction
  task automatic do_reset(input int w);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    chip_in_reset <= 1'b1;
    pkg_sel <= (w == 0) ? 2'h0 : ((w == 1) ? 2'h1 : 2'h2);
    has_adc <= (w == 1 || w == 2);
    m = exp_mask(w);
    shr = (w == 0) ? 32'h0000_0004 : 32'h0100_0000;
    d_m = '1;
    {od_m, o_m, al_m, ld} = '0;
    repeat (8) @(posedge clk_sys);
    cmp(pad_oe_n, ~shr, '1);
    cmp(pad_out, '0, shr);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chip_in_reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    cmp(port_present, m, '1);
    cmp(cfg_dir_in, '1, '1);
    cmp(pad_oe_n, '1, ~shr);
    cmp(grid_t'(srst_is_reset), 32'h1, 32'h1);
  endtask
  // Loads one port; open drain, drive and data are always random
  task automatic wr(input int q, input grid_t dr, input grid_t al, input grid_t wk, input grid_t pu);
    @(posedge clk_sys);
    {dir_w, alt_w, wk_w, pu_w} <= {dr, al, wk, pu};
    {od_w, dh_w, out_w} <= {$urandom, $urandom, $urandom};
    {a_out, a_oe, ext} <= {$urandom, $urandom, $urandom};
    cfg_we <= 4'h1 << q;
    @(posedge clk_sys);
    cfg_we <= 4'h0;
    #1;
    d_m[q] = dir_w[q] | ~m[q];
    od_m[q] = od_w[q] & m[q];
    o_m[q] = out_w[q] & m[q];
    al_m[q] = alt_w[q] & m[q];
    // LED sink always drives low; open drain releases a 1 from either source
    eoe = ~m | (~ld & ((al_m & (~a_oe | (od_m & a_out))) | (~al_m & (d_m | (od_m & o_m)))));
    care = ~shr;
    cmp(cfg_dir_in, d_m, ~shr);
    cmp(cfg_out_data, o_m, '1);
    cmp(pad_oe_n, eoe, care);
    cmp(pad_out, ~ld & ((al_m & a_out) | (~al_m & o_m)), care & ~eoe);
    cmp(pad_drive_high, dh_w & m, grid_t'(8'hff) << (8 * q));
    cmp(pad_pullup_en, pu_w & m, (grid_t'(8'hff) << (8 * q)) & ~shr);
  endtask
  task automatic wake(input int b, input logic e);
    logic s;
    s = 1'b0;
    @(posedge clk_sys);
    ext[0][b] <= ~ext[0][b];
    repeat (5) begin
      @(posedge clk_sys);
      #1 s = s | stop_wake;
    end
    cmp(grid_t'(s), grid_t'(e), 32'h1);
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(84414));
    for (v = 0; v < 4; v++) begin
      do_reset(v);
      // All-output corner first: absent pins must stay released
      for (i = 0; i < 24; i++) begin
        if (i < 4)
          wr(i, '0, '0, '0, '0);
        else
          wr($urandom_range(3), $urandom, $urandom, $urandom, $urandom);
      end
      wr(0, '1, '0, 32'h1, '0);
      repeat (4) @(posedge clk_sys);
      wake(0, 1'b1);
      wake(1, 1'b0);
      if (v >= 2) begin
        wr(2, '1, '0, '0, '0);
        @(posedge clk_sys);
        {led_en_wr, led_lvl_wr} <= 24'($urandom);
        led_we <= 1'b1;
        @(posedge clk_sys);
        led_we <= 1'b0;
        #1;
        ld = (grid_t'(led_en_wr) << 16) & m;
        cmp(grid_t'(led_level), grid_t'(led_lvl_wr), 32'hffff);
        cmp(pad_oe_n, grid_t'(~led_en_wr) << 16, 32'h00ff_0000);
        cmp(pad_out, '0, grid_t'(led_en_wr) << 16);
      end
      // A mode write during chip reset must be ignored
      @(posedge clk_sys);
      {chip_in_reset, srst_gpio_wr, srst_we} <= 3'h7;
      @(posedge clk_sys);
      {chip_in_reset, srst_we} <= 2'h0;
      @(posedge clk_sys);
      #1 cmp(grid_t'(srst_is_reset), 32'h1, 32'h1);
      @(posedge clk_sys);
      srst_we <= 1'b1;
      @(posedge clk_sys);
      srst_we <= 1'b0;
      #1 cmp(grid_t'(srst_is_reset), 32'h0, 32'h1);
      wr((v == 0) ? 0 : 3, '1, '0, '0, '0);
      cmp(pad_oe_n, (v == 0) ? shr : (od_m & o_m & shr), shr);
      @(posedge clk_sys);
      chip_in_reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 cmp(grid_t'(srst_is_reset), 32'h1, 32'h1);
      cmp(pad_oe_n | pad_out, '0, shr);
      $display("variant %0d done", v);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
